// ### src/gpf_pkg.sv
// Summary of operation
// - Start, end, carrier-extend and error propagation each go out as one special code group.
// - An idle is a comma in the even slot followed by the correcting or preserving odd code.
// - Configuration alternates two four-group sets: comma, marker, then the 16-bit word.
// - The receiver finds frames from ordered sets and drives GMII receive data, valid and error.
// - Enable rising in an even slot sends start of packet there, in place of the first preamble.
// - Enable rising in an odd slot finishes the idle first, then sends start in the next even slot.
// - A received start of packet is handed on as a preamble byte.
// - The preamble byte lost to idle completion is not recreated on receive.
// - Enable falling sends end of packet in the very next slot.
// - Alignment holds through the frame; end of packet in an even slot gets one carrier extend.
// - The first idle after a frame corrects when disparity is positive, later idles preserve.
// - The code-group stream goes to and comes from either the serial or the ten-bit path.
// - End of packet in an odd slot gets two carrier extends.
// - End of packet then two carrier extends gives one cycle of receive error with data 0x0F.
package gpf_pkg;

  // ----------------------------------------
  // code-group octets
  // ----------------------------------------
  localparam logic [7:0] GPF_K28_5 = 8'hBC;
  localparam logic [7:0] GPF_D5_6 = 8'hC5;
  localparam logic [7:0] GPF_D16_2 = 8'h50;
  localparam logic [7:0] GPF_D21_5 = 8'hB5;
  localparam logic [7:0] GPF_D2_2 = 8'h42;
  localparam logic [7:0] GPF_SOP = 8'hFB;
  localparam logic [7:0] GPF_EOP = 8'hFD;
  localparam logic [7:0] GPF_EXT = 8'hF7;
  localparam logic [7:0] GPF_ERR = 8'hFE;

  // ----------------------------------------
  // GMII values
  // ----------------------------------------
  localparam logic [7:0] GPF_PREAMBLE = 8'h55;
  localparam logic [7:0] GPF_FRAME_EXT = 8'h0F;

  // ----------------------------------------
  // config set slot indices and reset values
  // ----------------------------------------
  localparam logic [1:0] GPF_CFG_MARK = 2'h1;
  localparam logic [1:0] GPF_CFG_LOW = 2'h2;
  localparam logic [1:0] GPF_CFG_HIGH = 2'h3;
  localparam logic [1:0] GPF_CFG_IDX_RST = 2'h0;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic is_k;
    logic [7:0] data;
  } gpf_cg_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic [7:0] d;
  } gpf_gmii_s;

  localparam int GPF_CG_W = $bits(gpf_cg_s);
  localparam gpf_cg_s GPF_CG_RST = '{is_k: 1'b1, data: GPF_K28_5};
  localparam gpf_gmii_s GPF_GMII_RST = '{dv: 1'b0, er: 1'b0, d: 8'h00};

  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [5:0] {
    GPF_TX_IDLE = 6'b000001,
    GPF_TX_CFG = 6'b000010,
    GPF_TX_SOP = 6'b000100,
    GPF_TX_DATA = 6'b001000,
    GPF_TX_EXT2 = 6'b010000,
    GPF_TX_EXT1 = 6'b100000
  } gpf_tx_e;

  typedef enum logic [3:0] {
    GPF_RX_IDLE = 4'b0001,
    GPF_RX_DATA = 4'b0010,
    GPF_RX_T = 4'b0100,
    GPF_RX_TR = 4'b1000
  } gpf_rx_e;

endpackage : gpf_pkg

// ### src/gpf_skid.sv
`timescale 1ns/1ns
module gpf_skid
  import gpf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic in_valid,
  input gpf_cg_s in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output gpf_cg_s out_data,
  input wire logic out_ready
);

  gpf_cg_s head_r, head_nxt, tail_r, tail_nxt;
  logic head_vld_r, head_vld_nxt, tail_vld_r, tail_vld_nxt;
  logic push, pop;

  always_comb begin
    push = in_valid && !tail_vld_r;
    pop = head_vld_r && out_ready;
    head_nxt = head_r;
    tail_nxt = tail_r;
    head_vld_nxt = head_vld_r;
    tail_vld_nxt = tail_vld_r;
    if (pop) begin
      if (tail_vld_r) begin
        head_nxt = tail_r;
        tail_vld_nxt = 1'b0;
      end else begin
        head_nxt = in_data;
        head_vld_nxt = push;
      end
    end else if (push) begin
      if (head_vld_r) begin
        tail_nxt = in_data;
        tail_vld_nxt = 1'b1;
      end else begin
        head_nxt = in_data;
        head_vld_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_r <= GPF_CG_RST;
      tail_r <= GPF_CG_RST;
      head_vld_r <= 1'b0;
      tail_vld_r <= 1'b0;
    end else begin
      head_r <= head_nxt;
      tail_r <= tail_nxt;
      head_vld_r <= head_vld_nxt;
      tail_vld_r <= tail_vld_nxt;
    end
  end

  assign in_ready = !tail_vld_r;
  assign out_valid = head_vld_r;
  assign out_data = head_r;

endmodule : gpf_skid

// ### src/gpf_framer.sv
`timescale 1ns/1ns
module gpf_framer
  import gpf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // GMII transmit from the MAC
  input wire logic [7:0] gmii_txd,
  input wire logic gmii_tx_en,
  input wire logic gmii_tx_er,
  // configuration and disparity
  input wire logic cfg_en,
  input wire logic [15:0] cfg_word,
  input wire logic tx_rd_pos,
  input wire logic path_tbi,
  // transmit code groups to the encoder
  output logic tx_cg_valid,
  output gpf_cg_s tx_cg,
  input wire logic tx_cg_ready,
  output logic tx_path_tbi,
  // receive code groups from the decoder
  input gpf_cg_s rx_ser_cg,
  input gpf_cg_s rx_tbi_cg,
  // GMII receive to the MAC
  output gpf_gmii_s gmii_rx
);

  // ----------------------------------------
  // transmit engine
  // ----------------------------------------
  gpf_tx_e tx_st_r, tx_st_nxt;
  logic even_r, even_nxt;
  logic first_idle_r, first_idle_nxt;
  logic cfg_alt_r, cfg_alt_nxt;
  logic [1:0] cfg_idx_r, cfg_idx_nxt;
  logic path_r, path_nxt;
  logic adv, buf_in_ready;
  gpf_cg_s cg_out;

  function automatic gpf_cg_s mk_cg(input logic k, input logic [7:0] d);
    mk_cg = '{is_k: k, data: d};
  endfunction : mk_cg

  assign adv = buf_in_ready;

  always_comb begin
    tx_st_nxt = tx_st_r;
    first_idle_nxt = first_idle_r;
    cfg_alt_nxt = cfg_alt_r;
    cfg_idx_nxt = cfg_idx_r;
    cg_out = mk_cg(1'b1, GPF_K28_5);
    path_nxt = path_tbi;
    even_nxt = adv ? !even_r : even_r;
    case (tx_st_r)
      GPF_TX_IDLE: begin
        if (even_r) begin
          if (cfg_en) begin
            cg_out = mk_cg(1'b1, GPF_K28_5);
            cfg_idx_nxt = GPF_CFG_MARK;
            tx_st_nxt = GPF_TX_CFG;
          end else if (gmii_tx_en) begin
            cg_out = mk_cg(1'b1, GPF_SOP);
            tx_st_nxt = GPF_TX_DATA;
          end else begin
            cg_out = mk_cg(1'b1, GPF_K28_5);
          end
        end else begin
          cg_out = mk_cg(1'b0, (first_idle_r && tx_rd_pos) ? GPF_D5_6 : GPF_D16_2);
          first_idle_nxt = 1'b0;
          if (gmii_tx_en && !cfg_en) begin
            tx_st_nxt = GPF_TX_SOP;
          end
        end
      end
      GPF_TX_SOP: begin
        cg_out = mk_cg(1'b1, GPF_SOP);
        tx_st_nxt = GPF_TX_DATA;
      end
      GPF_TX_DATA: begin
        if (gmii_tx_en) begin
          cg_out = gmii_tx_er ? mk_cg(1'b1, GPF_ERR) : mk_cg(1'b0, gmii_txd);
        end else begin
          cg_out = mk_cg(1'b1, GPF_EOP);
          first_idle_nxt = 1'b1;
          tx_st_nxt = even_r ? GPF_TX_EXT1 : GPF_TX_EXT2;
        end
      end
      GPF_TX_EXT2: begin
        cg_out = mk_cg(1'b1, GPF_EXT);
        tx_st_nxt = GPF_TX_EXT1;
      end
      GPF_TX_EXT1: begin
        cg_out = mk_cg(1'b1, GPF_EXT);
        tx_st_nxt = GPF_TX_IDLE;
      end
      GPF_TX_CFG: begin
        case (cfg_idx_r)
          GPF_CFG_MARK: cg_out = mk_cg(1'b0, cfg_alt_r ? GPF_D2_2 : GPF_D21_5);
          GPF_CFG_LOW: cg_out = mk_cg(1'b0, cfg_word[7:0]);
          default: cg_out = mk_cg(1'b0, cfg_word[15:8]);
        endcase
        cfg_idx_nxt = cfg_idx_r + 2'h1;
        if (cfg_idx_r == GPF_CFG_HIGH) begin
          cfg_alt_nxt = !cfg_alt_r;
          tx_st_nxt = GPF_TX_IDLE;
        end
      end
      default: begin
        tx_st_nxt = GPF_TX_IDLE;
      end
    endcase
    if (!adv) begin
      tx_st_nxt = tx_st_r;
      first_idle_nxt = first_idle_r;
      cfg_alt_nxt = cfg_alt_r;
      cfg_idx_nxt = cfg_idx_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= GPF_TX_IDLE;
      even_r <= 1'b1;
      first_idle_r <= 1'b0;
      cfg_alt_r <= 1'b0;
      cfg_idx_r <= GPF_CFG_IDX_RST;
      path_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      even_r <= even_nxt;
      first_idle_r <= first_idle_nxt;
      cfg_alt_r <= cfg_alt_nxt;
      cfg_idx_r <= cfg_idx_nxt;
      path_r <= path_nxt;
    end
  end

  assign tx_path_tbi = path_r;

  // ----------------------------------------
  // output buffer, stall freezes the engine
  // ----------------------------------------
  gpf_skid u_skid (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(adv),
    .in_data(cg_out),
    .in_ready(buf_in_ready),
    .out_valid(tx_cg_valid),
    .out_data(tx_cg),
    .out_ready(tx_cg_ready)
  );

  // ----------------------------------------
  // receive engine
  // ----------------------------------------
  gpf_rx_e rx_st_r, rx_st_nxt;
  gpf_gmii_s rx_r, rx_nxt;
  gpf_cg_s rx_in;

  always_comb begin
    rx_in = path_r ? rx_tbi_cg : rx_ser_cg;
    rx_st_nxt = rx_st_r;
    rx_nxt = GPF_GMII_RST;
    case (rx_st_r)
      GPF_RX_IDLE: begin
        if (rx_in == mk_cg(1'b1, GPF_SOP)) begin
          rx_nxt = '{dv: 1'b1, er: 1'b0, d: GPF_PREAMBLE};
          rx_st_nxt = GPF_RX_DATA;
        end
      end
      GPF_RX_DATA: begin
        if (!rx_in.is_k) begin
          rx_nxt = '{dv: 1'b1, er: 1'b0, d: rx_in.data};
        end else if (rx_in.data == GPF_EOP) begin
          rx_st_nxt = GPF_RX_T;
        end else begin
          rx_nxt = '{dv: 1'b1, er: 1'b1, d: rx_in.data};
        end
      end
      GPF_RX_T: begin
        rx_st_nxt = (rx_in == mk_cg(1'b1, GPF_EXT)) ? GPF_RX_TR : GPF_RX_IDLE;
      end
      GPF_RX_TR: begin
        if (rx_in == mk_cg(1'b1, GPF_EXT)) begin
          rx_nxt = '{dv: 1'b0, er: 1'b1, d: GPF_FRAME_EXT};
        end
        rx_st_nxt = GPF_RX_IDLE;
      end
      default: begin
        rx_st_nxt = GPF_RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= GPF_RX_IDLE;
      rx_r <= GPF_GMII_RST;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign gmii_rx = rx_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_even_start;
    adv && tx_st_r == GPF_TX_IDLE && even_r && !cfg_en && gmii_tx_en;
  endsequence

  sequence s_odd_start;
    adv && tx_st_r == GPF_TX_IDLE && !even_r && !cfg_en && gmii_tx_en;
  endsequence

  sequence s_end_even;
    adv && tx_st_r == GPF_TX_DATA && !gmii_tx_en && even_r;
  endsequence

  sequence s_end_odd;
    adv && tx_st_r == GPF_TX_DATA && !gmii_tx_en && !even_r;
  endsequence

  sequence s_rx_trr;
    rx_st_r == GPF_RX_DATA && rx_in == mk_cg(1'b1, GPF_EOP)
      ##1 rx_in == mk_cg(1'b1, GPF_EXT) ##1 rx_in == mk_cg(1'b1, GPF_EXT);
  endsequence

  a_sop_even_slot: assert property (@(posedge clk) disable iff (!rst_n)
    s_even_start |-> cg_out == mk_cg(1'b1, GPF_SOP) ##1 tx_st_r == GPF_TX_DATA)
    else $error("start not sent in even slot");

  a_odd_sop_next: assert property (@(posedge clk) disable iff (!rst_n)
    s_odd_start |-> !cg_out.is_k ##1 (tx_st_r == GPF_TX_SOP && even_r))
    else $error("odd start did not finish idle then send start even");

  a_eop_no_delay: assert property (@(posedge clk) disable iff (!rst_n)
    adv && tx_st_r == GPF_TX_DATA && !gmii_tx_en |-> cg_out == mk_cg(1'b1, GPF_EOP))
    else $error("end of packet not sent at once");

  a_one_ext_even: assert property (@(posedge clk) disable iff (!rst_n)
    s_end_even ##1 adv |-> cg_out == mk_cg(1'b1, GPF_EXT) ##1 tx_st_r == GPF_TX_IDLE && even_r)
    else $error("even end not followed by one extend");

  a_two_ext_odd: assert property (@(posedge clk) disable iff (!rst_n)
    s_end_odd ##1 adv[*2] |-> tx_st_r == GPF_TX_EXT1 ##1 tx_st_r == GPF_TX_IDLE && even_r)
    else $error("odd end not followed by two extends");

  a_pos_toggle: assert property (@(posedge clk) disable iff (!rst_n)
    adv |=> even_r != $past(even_r))
    else $error("position flag did not toggle");

  a_idle_comma: assert property (@(posedge clk) disable iff (!rst_n)
    adv && tx_st_r == GPF_TX_IDLE && even_r && !gmii_tx_en |-> cg_out == mk_cg(1'b1, GPF_K28_5))
    else $error("idle comma missing in even slot");

  a_first_idle_fix: assert property (@(posedge clk) disable iff (!rst_n)
    adv && tx_st_r == GPF_TX_IDLE && !even_r && first_idle_r && tx_rd_pos
      |-> cg_out == mk_cg(1'b0, GPF_D5_6) ##1 !first_idle_r)
    else $error("first idle after frame not correcting");

  a_cfg_marker: assert property (@(posedge clk) disable iff (!rst_n)
    adv && tx_st_r == GPF_TX_CFG && cfg_idx_r == GPF_CFG_MARK
      |-> cg_out.data == (cfg_alt_r ? GPF_D2_2 : GPF_D21_5))
    else $error("config marker wrong");

  a_rx_sop_pre: assert property (@(posedge clk) disable iff (!rst_n)
    rx_st_r == GPF_RX_IDLE && rx_in == mk_cg(1'b1, GPF_SOP)
      |=> gmii_rx.dv && gmii_rx.d == GPF_PREAMBLE)
    else $error("received start not turned into preamble");

  a_rx_frame_ext: assert property (@(posedge clk) disable iff (!rst_n)
    s_rx_trr |=> gmii_rx.er && !gmii_rx.dv && gmii_rx.d == GPF_FRAME_EXT ##1 !gmii_rx.er)
    else $error("frame extension not shown for one cycle");

endmodule : gpf_framer

// ### test/gpf_enc_model.sv
`timescale 1ns/1ns
module gpf_enc_model
  import gpf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // code groups from the framer
  input wire logic tx_cg_valid,
  input gpf_cg_s tx_cg,
  output logic tx_cg_ready,
  // stall request from the bench
  input wire logic stall
);
  gpf_cg_s seen_q[$];

  assign tx_cg_ready = !stall;

  // accepted code groups, in wire order
  always @(posedge clk) begin
    if (rst_n && tx_cg_valid && tx_cg_ready) begin
      seen_q.push_back(tx_cg);
    end
  end
endmodule : gpf_enc_model

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench
  import gpf_pkg::*;
;
  typedef struct {int len; int gap; logic rd; int er_at;} gpf_row_s;
  logic clk, rst_n, tx_en, tx_er, cfg_en, rd_pos, path_tbi, stall;
  logic [7:0] txd;
  logic [15:0] cfg_word;
  logic tx_cg_valid, tx_cg_ready, tx_path_tbi;
  gpf_cg_s tx_cg, rx_ser, rx_tbi;
  gpf_gmii_s gmii_rx;
  int errors, num_checks, hits;
  gpf_row_s rows[5] = '{'{9, 12, 0, -1}, '{9, 12, 1, 4}, '{9, 13, 0, -1},
    '{10, 12, 1, -1}, '{10, 13, 0, 6}};
  logic [8:0] cfg_exp[8] = '{9'h1BC, 9'h0B5, 9'h0C3, 9'h0A4, 9'h1BC, 9'h042, 9'h0C3, 9'h0A4};

  gpf_framer dut (.clk(clk), .rst_n(rst_n), .gmii_txd(txd), .gmii_tx_en(tx_en),
    .gmii_tx_er(tx_er), .cfg_en(cfg_en), .cfg_word(cfg_word), .tx_rd_pos(rd_pos),
    .path_tbi(path_tbi), .tx_cg_valid(tx_cg_valid), .tx_cg(tx_cg),
    .tx_cg_ready(tx_cg_ready), .tx_path_tbi(tx_path_tbi), .rx_ser_cg(rx_ser),
    .rx_tbi_cg(rx_tbi), .gmii_rx(gmii_rx));
  gpf_enc_model enc (.clk(clk), .rst_n(rst_n), .tx_cg_valid(tx_cg_valid), .tx_cg(tx_cg),
    .tx_cg_ready(tx_cg_ready), .stall(stall));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  // ----
  // helpers
  // ----
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cg_at(input int i, input logic [8:0] exp);
    check($sformatf("cg%0d", i), 16'(enc.seen_q[i]), 16'(exp));
  endtask : cg_at

  // drives the selected path, garbage on the other
  task automatic rx_step(input logic [8:0] cg);
    rx_tbi = path_tbi ? cg : ~cg;
    rx_ser = path_tbi ? ~cg : cg;
    @(negedge clk);
  endtask : rx_step

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    print_verdict();
  end

  // ----
  // main sequence
  // ----
  initial begin
    int p, t, d, s;
    errors = 0;
    num_checks = 0;
    hits = 0;
    rst_n = 0;
    {tx_en, tx_er, cfg_en, rd_pos, path_tbi, stall} = '0;
    txd = 8'h00;
    cfg_word = 16'hA4C3;
    rx_ser = GPF_CG_RST;
    rx_tbi = GPF_CG_RST;
    repeat (3) @(negedge clk);
    check("rst_tx", 16'({tx_cg_valid, tx_cg, tx_path_tbi}), 16'h0378);
    check("rst_rx", 16'(gmii_rx), 16'h0000);
    rst_n = 1;
    repeat (4) @(negedge clk);
    // frames at both alignments and both end parities
    foreach (rows[r]) begin
      s = enc.seen_q.size();
      rd_pos = rows[r].rd;
      for (int i = 0; i < rows[r].len; i++) begin
        tx_en = 1;
        txd = 8'h10 + 8'(i);
        tx_er = (i == rows[r].er_at);
        @(negedge clk);
      end
      tx_en = 0;
      tx_er = 0;
      repeat (rows[r].gap) @(negedge clk);
      p = s;
      while (p < enc.seen_q.size() && enc.seen_q[p] !== {1'b1, GPF_SOP}) p++;
      // next slot is s + 1: even start replaces byte 0, odd start loses it
      d = (s % 2) ? 1 : 2;
      check("sop_pos", 16'(p % 2), 16'h0000);
      check("sop_slot", 16'(p - s), 16'(d));
      if (d == 2) begin
        hits++;
        cg_at(p - 1, {1'b0, GPF_D16_2});
        cg_at(p - 2, {1'b1, GPF_K28_5});
      end
      for (int i = d; i < rows[r].len; i++) begin
        cg_at(p + 1 + i - d, (i == rows[r].er_at) ? {1'b1, GPF_ERR} : {1'b0, 8'h10 + 8'(i)});
      end
      t = p + 1 + rows[r].len - d;
      cg_at(t, {1'b1, GPF_EOP});
      cg_at(t + 1, {1'b1, GPF_EXT});
      if (t % 2) cg_at(t + 2, {1'b1, GPF_EXT});
      t = t + 2 + t % 2;
      cg_at(t, {1'b1, GPF_K28_5});
      cg_at(t + 1, {1'b0, rows[r].rd ? GPF_D5_6 : GPF_D16_2});
      cg_at(t + 3, {1'b0, GPF_D16_2});
    end
    check("odd_start", 16'(hits > 0), 16'h0001);
    // configuration sets
    s = enc.seen_q.size();
    cfg_en = 1;
    repeat (12) @(negedge clk);
    cfg_en = 0;
    repeat (10) @(negedge clk);
    p = s;
    while (p < enc.seen_q.size() && enc.seen_q[p] !== {1'b0, GPF_D21_5}) p++;
    check("cfg_pos", 16'(p % 2), 16'h0001);
    for (int i = 0; i < 8; i++) cg_at(p - 1 + i, cfg_exp[i]);
    // encoder stall fills the buffer, no group lost
    s = enc.seen_q.size();
    stall = 1;
    repeat (6) @(negedge clk);
    check("stall_valid", 16'(tx_cg_valid), 16'h0001);
    stall = 0;
    repeat (12) @(negedge clk);
    for (int i = s; i < s + 10; i++) cg_at(i, (i % 2) ? 9'h050 : 9'h1BC);
    // receive over the serial path
    rx_step({1'b1, GPF_SOP});
    check("rx_sop", 16'(gmii_rx), 16'h0255);
    rx_step(9'h011);
    check("rx_d1", 16'(gmii_rx), 16'h0211);
    rx_step({1'b1, GPF_EOP});
    check("rx_eop", 16'(gmii_rx), 16'h0000);
    hits = 0;
    foreach (cfg_exp[i]) begin
      rx_step(i < 2 ? {1'b1, GPF_EXT} : GPF_CG_RST);
      hits += (gmii_rx === 10'h10F);
    end
    check("rx_ext", 16'(hits), 16'h0001);
    // receive over the ten-bit path
    path_tbi = 1;
    rx_step(GPF_CG_RST);
    rx_step(GPF_CG_RST);
    check("path", 16'(tx_path_tbi), 16'h0001);
    rx_step({1'b1, GPF_SOP});
    check("tbi_sop", 16'(gmii_rx), 16'h0255);
    rx_step({1'b1, GPF_EXT});
    check("rx_kerr", 16'(gmii_rx[9:8]), 16'h0003);
    rx_step({1'b1, GPF_EOP});
    hits = 0;
    foreach (cfg_exp[i]) begin
      rx_step(i < 1 ? {1'b1, GPF_EXT} : GPF_CG_RST);
      hits += (gmii_rx === 10'h10F);
    end
    check("rx_noext", 16'(hits), 16'h0000);
    // reset in mid-run restarts with an even idle
    rst_n = 0;
    @(negedge clk);
    check("rst2_tx", 16'({tx_cg_valid, tx_cg, tx_path_tbi}), 16'h0378);
    check("rst2_rx", 16'(gmii_rx), 16'h0000);
    s = enc.seen_q.size();
    rst_n = 1;
    repeat (4) @(negedge clk);
    cg_at(s, 9'h1BC);
    cg_at(s + 1, 9'h050);
    print_verdict();
  end
endmodule : testbench
